/* File: adc_sequence_control.sv */
// Converter control register, sample/convert sequencing and result format.
// Assumes trigger strobes from the timer and charge unit are on clk;
// the external pin is asynchronous. The analog core returns one sample.
module adc_sequence_control
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        write,
  input  wire logic        read,
  output logic      [15:0] rdata,
  // System and trigger inputs
  input  wire logic        cpu_idle,
  input  wire logic        timer_match,
  input  wire logic        charge_event,
  input  wire logic        trigger_pin,
  // Analog core
  input  wire logic [9:0]  sample_value,
  output logic             sampling,
  // Outputs
  output logic      [15:0] result,
  output logic             irq
);

  state_type   s;
  state_type   next_s;
  reg_req_type req;

  assign req = '{write: write, read: read, addr: addr, wdata: wdata};

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] format_result(input format_type f, input logic [9:0] v);
    case (f)
      fmt_uint:  format_result = {6'h00, v};
      fmt_sint:  format_result = {{6{~v[9]}}, ~v[9], v[8:0]};
      fmt_frac:  format_result = {v, 6'h00};
      fmt_sfrac: format_result = {~v[9], v[8:0], 6'h00};
      default:   format_result = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] ctrl_word(input state_type st);
    ctrl_word = {st.converter_on, 1'b0, st.idle_stop, 3'h0, st.output_format,
                 st.trigger_source_select, 2'h0, st.auto_sample, st.sample_enable, st.done};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic halted;
  logic pin_edge;
  logic fire;
  logic armed;
  logic starting;
  logic ctrl_write;

  assign halted     = s.idle_stop && cpu_idle;
  assign pin_edge   = s.pin_sync[1] && !s.pin_last;
  assign armed      = s.converter_on && !halted && s.phase == st_sample;
  assign starting   = armed && fire;
  assign ctrl_write = write && addr == ctrl_one_offset;

  always_comb begin
    case (s.trigger_source_select)
      trig_charge: fire = charge_event;
      trig_timer:  fire = timer_match;
      trig_pin:    fire = pin_edge;
      default:     fire = 1'b0;
    endcase
  end

  always_comb begin
    next_s          = s;
    next_s.pin_sync = {s.pin_sync[0], trigger_pin};
    next_s.pin_last = s.pin_sync[1];
    next_s.rdata    = 16'h0000;

    if (req.read) begin
      case (req.addr)
        ctrl_one_offset:   next_s.rdata = ctrl_word(s);
        int_status_offset: next_s.rdata = {14'h0000, s.irq_status};
        int_mask_offset:   next_s.rdata = {14'h0000, s.irq_mask};
        result_offset:     next_s.rdata = format_result(s.output_format, s.result_buffer_word);
        default:           next_s.rdata = 16'h0000;
      endcase
    end

    if (req.write && req.addr == ctrl_one_offset) begin
      next_s.converter_on          = req.wdata[converter_on_bit];
      next_s.idle_stop             = req.wdata[idle_stop_bit];
      next_s.output_format         = format_type'(req.wdata[format_lsb +: 2]);
      next_s.trigger_source_select = req.wdata[trigger_lsb +: 3];
      next_s.auto_sample           = req.wdata[auto_sample_bit];
      next_s.done                  = req.wdata[done_bit];
      if (req.wdata[sample_enable_bit] && s.phase == st_hold)
        next_s.phase = st_sample;
    end
    if (req.write && req.addr == int_mask_offset)
      next_s.irq_mask = req.wdata[1:0];
    // Clears come before the sequence so a same-cycle event wins
    if (req.write && req.addr == int_status_offset)
      next_s.irq_status = s.irq_status & ~req.wdata[1:0];

    if (!s.converter_on) begin
      next_s.phase = (next_s.converter_on && next_s.auto_sample) ? st_sample : st_hold;
      next_s.result_buffer_word = 10'h000;
    end else if (!next_s.converter_on) begin
      next_s.phase              = st_off;
      next_s.result_buffer_word = 10'h000;
    end else if (!halted) begin
      case (s.phase)
        st_sample: begin
          if (fire) begin
            next_s.phase = st_convert;
            next_s.count = convert_cycles;
            // Done stands until the next conversion starts or a control write clears it
            next_s.done  = 1'b0;
            next_s.irq_status[irq_trigger_bit] = 1'b1;
          end
        end
        st_convert: begin
          if (s.count == 4'h1) begin
            next_s.result_buffer_word = sample_value;
            next_s.done = 1'b1;
            next_s.irq_status[irq_done_bit] = 1'b1;
            next_s.phase = next_s.auto_sample ? st_sample : st_hold;
          end else begin
            next_s.count = s.count - 4'h1;
          end
        end
        st_hold, st_off: ;
        default: next_s.phase = st_hold;
      endcase
    end
    if (req.write && req.addr == ctrl_one_offset && !req.wdata[sample_enable_bit]
        && s.phase == st_sample)
      next_s.phase = st_hold;
    next_s.sample_enable = (next_s.phase == st_sample);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata    = s.rdata;
  assign sampling = s.sample_enable;
  assign result   = format_result(s.output_format, s.result_buffer_word);
  assign irq      = |(s.irq_status & s.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  sequence conv_start;
    starting;
  endsequence

  // Cycles 1 to 12 of an undisturbed conversion
  sequence conv_run;
    (!write && !cpu_idle) [*8] ##1 (!write && !cpu_idle) [*4];
  endsequence

  sequence conv_last;
    s.phase == st_convert && s.count == 4'h1 && s.converter_on && !halted && !ctrl_write;
  endsequence

  a_trigger_ends_sample: assert property (@(posedge clk) disable iff (!nrst)
    conv_start and !ctrl_write |=> !s.sample_enable)
    else $error("sample bit still set after trigger");

  a_convert_done_time: assert property (@(posedge clk) disable iff (!nrst)
    (conv_start and (!write && !cpu_idle)) ##1 conv_run |=> s.done)
    else $error("done not set after conversion");

  a_idle_stop_halts: assert property (@(posedge clk) disable iff (!nrst)
    halted && !write && s.phase == st_convert |=> $stable(s.count))
    else $error("conversion advanced during idle stop");

  a_auto_resample: assert property (@(posedge clk) disable iff (!nrst)
    s.phase == st_convert && s.count == 4'h1 && !halted && s.auto_sample && !write
    |=> s.sample_enable)
    else $error("auto sample did not restart");

  a_manual_no_sample: assert property (@(posedge clk) disable iff (!nrst)
    s.phase == st_hold && s.converter_on && !write |=> !s.sample_enable)
    else $error("sampling began without software");

  a_disable_clears: assert property (@(posedge clk) disable iff (!nrst)
    !s.converter_on |=> s.result_buffer_word == 10'h000)
    else $error("result kept while disabled");

  a_format_frac_low: assert property (@(posedge clk) disable iff (!nrst)
    s.output_format[1] |-> result[5:0] == 6'h00)
    else $error("fraction low bits not zero");

  a_reserved_no_fire: assert property (@(posedge clk) disable iff (!nrst)
    s.trigger_source_select inside {3'b011, 3'b100, 3'b101} && s.phase == st_sample
    && !write |=> s.phase == st_sample)
    else $error("reserved code started conversion");

  // End of conversion and the done flag
  a_done_sets_status: assert property (@(posedge clk) disable iff (!nrst)
    conv_last |=> s.irq_status[irq_done_bit])
    else $error("done status bit not set");

  a_result_captured: assert property (@(posedge clk) disable iff (!nrst)
    conv_last |=> s.result_buffer_word == $past(sample_value))
    else $error("sample not captured at end of conversion");

  a_done_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    conv_last |=> s.done)
    else $error("done flag not set at end of conversion");

  a_done_stands: assert property (@(posedge clk) disable iff (!nrst)
    s.done && !ctrl_write && !starting |=> s.done)
    else $error("done flag dropped without cause");

  a_manual_hold_after: assert property (@(posedge clk) disable iff (!nrst)
    (conv_last and !s.auto_sample) |=> !s.sample_enable)
    else $error("manual mode resampled by itself");

  a_convert_ignores_fire: assert property (@(posedge clk) disable iff (!nrst)
    s.phase == st_convert && s.count != 4'h1 && s.converter_on && !ctrl_write
    |=> s.phase == st_convert)
    else $error("conversion cut short");

  // Trigger paths, each only while sampling
  a_pin_edge_fires: assert property (@(posedge clk) disable iff (!nrst)
    armed && !ctrl_write && s.trigger_source_select == trig_pin && pin_edge
    |=> s.phase == st_convert)
    else $error("pin edge did not start conversion");

  a_timer_fires: assert property (@(posedge clk) disable iff (!nrst)
    armed && !ctrl_write && s.trigger_source_select == trig_timer && timer_match
    |=> s.phase == st_convert)
    else $error("timer match did not start conversion");

  a_charge_fires: assert property (@(posedge clk) disable iff (!nrst)
    armed && !ctrl_write && s.trigger_source_select == trig_charge && charge_event
    |=> s.phase == st_convert)
    else $error("charge event did not start conversion");

  // Idle handling
  a_idle_continues: assert property (@(posedge clk) disable iff (!nrst)
    !s.idle_stop && cpu_idle && s.converter_on && s.phase == st_convert && s.count != 4'h1
    && !ctrl_write |=> s.count == $past(s.count) - 4'h1)
    else $error("conversion stalled in idle without stop");

  a_halt_keeps_phase: assert property (@(posedge clk) disable iff (!nrst)
    halted && !write && s.phase == st_sample |=> s.phase == st_sample)
    else $error("sampling ended during idle stop");

  // Software control of sampling and enable
  a_sw_starts_sample: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_write && wdata[converter_on_bit] && wdata[sample_enable_bit] && s.converter_on
    && s.phase == st_hold |=> s.sample_enable)
    else $error("software sample request ignored");

  a_sw_stops_sample: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_write && !wdata[sample_enable_bit] && s.phase == st_sample |=> !s.sample_enable)
    else $error("software sample clear ignored");

  a_disable_zeroes: assert property (@(posedge clk) disable iff (!nrst)
    s.converter_on && ctrl_write && !wdata[converter_on_bit]
    |=> s.result_buffer_word == 10'h000 && !s.sample_enable)
    else $error("disable kept result or sampling");

  a_off_no_sample: assert property (@(posedge clk) disable iff (!nrst)
    !s.converter_on |-> !s.sample_enable)
    else $error("sampling while converter off");

  a_read_sample_bit: assert property (@(posedge clk) disable iff (!nrst)
    read && addr == ctrl_one_offset |=> rdata[sample_enable_bit] == $past(s.sample_enable))
    else $error("sample bit misread");

  a_read_done_bit: assert property (@(posedge clk) disable iff (!nrst)
    read && addr == ctrl_one_offset |=> rdata[done_bit] == $past(s.done))
    else $error("done bit misread");

  // Result alignment in each format
  a_uint_high_zero: assert property (@(posedge clk) disable iff (!nrst)
    s.output_format == fmt_uint |-> result[15:10] == 6'h00)
    else $error("integer high bits not zero");

  a_sint_sign_ext: assert property (@(posedge clk) disable iff (!nrst)
    s.output_format == fmt_sint |-> result[15:10] == {6{result[9]}})
    else $error("signed integer not sign extended");

  a_frac_left_align: assert property (@(posedge clk) disable iff (!nrst)
    s.output_format == fmt_frac |-> result[15:6] == s.result_buffer_word)
    else $error("fraction not left justified");

  a_sfrac_left_align: assert property (@(posedge clk) disable iff (!nrst)
    s.output_format == fmt_sfrac |-> result[14:6] == s.result_buffer_word[8:0])
    else $error("signed fraction not left justified");

endmodule // adc_sequence_control

/* File: adc_seq_pkg.sv */
// Package for the converter sequence control block.
// Assumes one 250 MHz clock and a plain register port with 16-bit data.
package adc_seq_pkg;

  // Register map (word offsets chosen for this block)
  localparam logic [3:0] ctrl_one_offset   = 4'h0;
  localparam logic [3:0] int_status_offset = 4'h1;
  localparam logic [3:0] int_mask_offset   = 4'h2;
  localparam logic [3:0] result_offset     = 4'h3;

  // Field positions of converter_control_one
  localparam int converter_on_bit  = 15;
  localparam int idle_stop_bit     = 13;
  localparam int format_lsb        = 8;
  localparam int trigger_lsb       = 5;
  localparam int auto_sample_bit   = 2;
  localparam int sample_enable_bit = 1;
  localparam int done_bit          = 0;
  localparam logic [15:0] ctrl_write_mask = 16'ha3e6;
  localparam logic [15:0] ctrl_reset      = 16'h0000;

  // Conversion length in cycles
  localparam logic [3:0] convert_cycles = 4'hc;

  // Interrupt status bits
  localparam int irq_done_bit    = 0;
  localparam int irq_trigger_bit = 1;

  typedef enum logic [1:0] {
    fmt_uint  = 2'b00,
    fmt_sint  = 2'b01,
    fmt_frac  = 2'b10,
    fmt_sfrac = 2'b11
  } format_type;

  typedef enum logic [2:0] {
    trig_manual = 3'b000,
    trig_pin    = 3'b001,
    trig_timer  = 3'b010,
    trig_charge = 3'b110
  } trigger_type;

  typedef enum logic [1:0] {
    st_off     = 2'b00,
    st_sample  = 2'b01,
    st_convert = 2'b10,
    st_hold    = 2'b11
  } phase_type;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic        converter_on;
    logic        idle_stop;
    format_type  output_format;
    logic [2:0]  trigger_source_select;
    logic        auto_sample;
    logic        sample_enable;
    logic        done;
    phase_type   phase;
    logic [3:0]  count;
    logic [9:0]  result_buffer_word;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [15:0] rdata;
    logic [1:0]  pin_sync;
    logic        pin_last;
  } state_type;

endpackage

/* File: adc_sequence_control_tb.sv */
// Testbench for the converter sequence control block.
// Assumes the register map and conversion length of adc_seq_pkg.
module adc_sequence_control_tb
  import adc_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, write, read, cpu_idle, timer_match, charge_event, trigger_pin;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, result;
  logic [9:0]  sample_value;
  logic        sampling, irq;
  int          n_errors, n_tests;
  // Sample 2a5 in each of the four formats
  logic [15:0] fmt_exp [4] = '{16'h02a5, 16'h00a5, 16'ha940, 16'h2940};

  adc_sequence_control i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .write(write), .read(read), .rdata(rdata), .cpu_idle(cpu_idle),
    .timer_match(timer_match), .charge_event(charge_event), .trigger_pin(trigger_pin),
    .sample_value(sample_value), .sampling(sampling), .result(result), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    {write, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    {read, addr} <= {1'b1, a};
    @(posedge clk);
    read <= 1'b0;
    @(negedge clk);
    chk(what, rdata, exp);
  endtask

  // Bits: charge event, timer match, pin level (pin left as set)
  task automatic trig(input logic [2:0] p);
    @(posedge clk);
    {charge_event, timer_match, trigger_pin} <= p;
    @(posedge clk);
    {charge_event, timer_match} <= 2'b00;
  endtask

  task automatic wait_for(input bit on_irq, input logic lvl);
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if ((on_irq ? irq : sampling) === lvl) break;
    end
    if (i == 40) begin
      chk("wait level", {15'h0, ~lvl}, {15'h0, lvl});
      results();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, write, read, timer_match, charge_event, trigger_pin} = '0;
    {addr, wdata, n_errors, n_tests} = '0;
    cpu_idle = 1'b1;
    sample_value = 10'h2a5;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd("control reset", ctrl_one_offset, ctrl_reset);
    rd("unmapped", 4'h7, 16'h0000);
    wr(int_mask_offset, 16'h0001);
    // Idle without stop: conversion must still finish
    wr(ctrl_one_offset, 16'h8044);
    wait_for(0, 1'b1);
    trig(3'b010);
    @(negedge clk);
    chk("sampling after timer", sampling, 16'h0);
    wait_for(1, 1'b1);
    chk("auto resample", sampling, 16'h1);
    rd("done after auto", ctrl_one_offset, 16'h8047);
    for (int f = 0; f < 4; f++) begin
      wr(ctrl_one_offset, {6'h20, f[1:0], 8'h04});
      rd("result format", result_offset, fmt_exp[f]);
      chk("result port", result, fmt_exp[f]);
    end
    rd("irq status", int_status_offset, 16'h0003);
    wr(int_mask_offset, 16'h0000);
    @(negedge clk);
    chk("irq masked", irq, 16'h0);
    wr(int_status_offset, 16'h0003);
    rd("status cleared", int_status_offset, 16'h0000);
    wr(int_mask_offset, 16'h0001);
    // Manual sampling, pin edge trigger
    cpu_idle <= 1'b0;
    wr(ctrl_one_offset, 16'h8022);
    trig(3'b001);
    wait_for(0, 1'b0);
    wait_for(1, 1'b1);
    chk("no resample", sampling, 16'h0);
    rd("done flag", ctrl_one_offset, 16'h8021);
    wr(int_status_offset, 16'h0001);
    trig(3'b000);
    wr(ctrl_one_offset, 16'h80c2);
    trig(3'b100);
    @(negedge clk);
    chk("charge trigger", sampling, 16'h0);
    wait_for(1, 1'b1);
    wr(int_status_offset, 16'h0001);
    for (int c = 3; c < 6; c++) begin
      wr(ctrl_one_offset, {8'h80, c[2:0], 5'h02});
      trig(3'b110);
      @(negedge clk);
      chk("reserved code", sampling, 16'h1);
    end
    // Idle with stop set freezes a running conversion
    wr(ctrl_one_offset, 16'ha046);
    wait_for(0, 1'b1);
    sample_value <= 10'h15a;
    trig(3'b010);
    cpu_idle <= 1'b1;
    repeat (20) @(negedge clk);
    chk("frozen in idle", irq, 16'h0);
    @(posedge clk);
    cpu_idle <= 1'b0;
    wait_for(1, 1'b1);
    rd("result held", result_offset, 16'h015a);
    wr(ctrl_one_offset, 16'h0000);
    rd("result lost", result_offset, 16'h0000);
    // Reset in mid-run returns every output to zero
    wr(ctrl_one_offset, 16'h8044);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("irq after reset", irq, 16'h0);
    chk("sampling after reset", sampling, 16'h0);
    rd("control after reset", ctrl_one_offset, ctrl_reset);
    results();
  end
endmodule // adc_sequence_control_tb
